// ### core/fir_consts.svh
`ifndef FIR_CONSTS_SVH
`define FIR_CONSTS_SVH

// Relay matrix geometry
`define FIR_NCH            16
`define FIR_RPC            7
`define FIR_NREL           112
`define FIR_CH_PER_WORD    4
`define FIR_STAGE_WORDS    4

// Relay positions inside one channel group
`define FIR_REL_LOAD_P     0
`define FIR_REL_SHORT      1
`define FIR_REL_P_RAIL_A   2
`define FIR_REL_P_RAIL_B   3
`define FIR_REL_N_RAIL_A   4
`define FIR_REL_N_RAIL_B   5
`define FIR_REL_LOAD_N     6

// Input threshold groups
`define FIR_THR_GROUPS     4
`define FIR_THR_GRP_CH     8
`define FIR_THR_BITS       8

// Register byte offsets
`define FIR_OFS_CTRL       12'h000
`define FIR_OFS_STAT       12'h004
`define FIR_OFS_IRQ_STS    12'h008
`define FIR_OFS_IRQ_MSK    12'h00C
`define FIR_OFS_STAGE0     12'h010
`define FIR_OFS_ACTIVE0    12'h020
`define FIR_OFS_THR_HI     12'h030
`define FIR_OFS_THR_LO     12'h034
`define FIR_OFS_SETTLE     12'h038

// Field positions
`define FIR_CTRL_APPLY     0
`define FIR_CTRL_HOST_ACT  1
`define FIR_CTRL_FAULT_CLR 2
`define FIR_STAT_BUSY      0
`define FIR_STAT_FAULT     1
`define FIR_STAT_NONDEF    2
`define FIR_STS_DONE       0
`define FIR_STS_REJECT     1
`define FIR_STS_BITS       2

// Reset values
`define FIR_THR_HI_RST     32'h80808080
`define FIR_THR_LO_RST     32'h40404040

// Timing
`define FIR_CLK_PERIOD_NS  25
`define FIR_SETTLE_NS      500000
`define FIR_SETTLE_CYC     ((`FIR_SETTLE_NS + `FIR_CLK_PERIOD_NS - 1) / `FIR_CLK_PERIOD_NS)
`define FIR_BLINK_HALF_NS  250000000
`define FIR_BLINK_CYC      (`FIR_BLINK_HALF_NS / `FIR_CLK_PERIOD_NS)

`endif

// ### core/fir_pkg.sv
package fir_pkg;
   typedef enum logic [0:0] {
      FIR_IDLE   = 1'b0,
      FIR_SETTLE = 1'b1
   } fir_state_t;
endpackage

// ### core/fir_blink.sv
module fir_blink #(
   parameter int HALF_CYC = 10000000
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   output logic      blink
);
   logic [31:0] cnt_ff;
   logic        blink_ff;

   // Square wave for the blinking LED states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff   <= 32'h00000000;
         blink_ff <= 1'b0;
      end else if (cnt_ff >= 32'(HALF_CYC - 1)) begin
         cnt_ff   <= 32'h00000000;
         blink_ff <= ~blink_ff;
      end else begin
         cnt_ff <= cnt_ff + 32'h00000001;
      end
   end

   assign blink = blink_ff;
endmodule

// ### core/fir_top.sv
`include "fir_consts.svh"

module fir_top #(
   parameter int SETTLE_CYC = `FIR_SETTLE_CYC,
   parameter int BLINK_CYC  = `FIR_BLINK_CYC
) (
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   input  wire logic                  power_good,
   input  wire logic                  chassis_ready_n_rst,
   output logic      [`FIR_NREL-1:0]  relay_drive,
   output logic      [31:0]           thr_high,
   output logic      [31:0]           thr_low,
   output logic                       irq,
   output logic                       led_pwr_green,
   output logic                       led_pwr_red,
   output logic                       led_rdy_green,
   output logic                       led_rdy_amber
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [`FIR_NREL-1:0]      stage_ff;
   logic [`FIR_NREL-1:0]      pend_ff;
   logic [`FIR_NREL-1:0]      relay_ff;
   logic [`FIR_NREL-1:0]      keep_mask;
   logic [`FIR_NCH-1:0]       ch_ok;
   logic [`FIR_NCH-1:0]       rail_clash;
   logic [`FIR_NCH-1:0]       short_clash;
   logic [31:0]               thr_hi_ff;
   logic [31:0]               thr_lo_ff;
   logic [31:0]               settle_ff;
   logic [31:0]               cnt_ff;
   logic [31:0]               hrdata_ff;
   logic [31:0]               rd_val;
   logic [11:0]               wr_addr_ff;
   logic                      wr_pend_ff;
   logic                      host_act_ff;
   logic                      fault_ff;
   logic [`FIR_STS_BITS-1:0]  sts_ff;
   logic [`FIR_STS_BITS-1:0]  msk_ff;
   logic [`FIR_STS_BITS-1:0]  nxt_sts;
   logic                      irq_ff;
   logic                      led_pg_ff;
   logic                      led_pr_ff;
   logic                      led_rg_ff;
   logic                      led_ra_ff;
   logic                      blink;
   logic                      addr_phase;
   logic                      wr_ctrl;
   logic                      apply_req;
   logic                      cfg_ok;
   logic                      apply_ok;
   logic                      reject;
   logic                      settle_done;
   logic                      nondefault;
   fir_pkg::fir_state_t       state_ff;

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, always OKAY

   assign addr_phase = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 12'h000;
      end else begin
         wr_pend_ff <= addr_phase && hwrite;
         wr_addr_ff <= {haddr[11:2], 2'b00};
      end
   end

   // Read data captured at the address phase, presented in the data phase
   always_comb begin
      rd_val = 32'h00000000;
      case ({haddr[11:2], 2'b00})
         `FIR_OFS_CTRL:    rd_val[`FIR_CTRL_HOST_ACT] = host_act_ff;
         `FIR_OFS_STAT: begin
            rd_val[`FIR_STAT_BUSY]   = (state_ff == fir_pkg::FIR_SETTLE);
            rd_val[`FIR_STAT_FAULT]  = fault_ff;
            rd_val[`FIR_STAT_NONDEF] = nondefault;
         end
         `FIR_OFS_IRQ_STS: rd_val[`FIR_STS_BITS-1:0] = sts_ff;
         `FIR_OFS_IRQ_MSK: rd_val[`FIR_STS_BITS-1:0] = msk_ff;
         `FIR_OFS_THR_HI:  rd_val = thr_hi_ff;
         `FIR_OFS_THR_LO:  rd_val = thr_lo_ff;
         `FIR_OFS_SETTLE:  rd_val = settle_ff;
         default: begin
            for (int k = 0; k < `FIR_STAGE_WORDS; k++) begin
               for (int j = 0; j < `FIR_CH_PER_WORD; j++) begin
                  if ({haddr[11:2], 2'b00} == `FIR_OFS_STAGE0 + 12'(4 * k)) begin
                     rd_val[j*8 +: `FIR_RPC] = stage_ff[(k*`FIR_CH_PER_WORD+j)*`FIR_RPC +: `FIR_RPC];
                  end
                  if ({haddr[11:2], 2'b00} == `FIR_OFS_ACTIVE0 + 12'(4 * k)) begin
                     rd_val[j*8 +: `FIR_RPC] = relay_ff[(k*`FIR_CH_PER_WORD+j)*`FIR_RPC +: `FIR_RPC];
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h00000000;
      end else if (addr_phase && !hwrite) begin
         hrdata_ff <= rd_val;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control, threshold and settle registers

   assign wr_ctrl   = wr_pend_ff && (wr_addr_ff == `FIR_OFS_CTRL);
   assign apply_req = wr_ctrl && hwdata[`FIR_CTRL_APPLY];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         host_act_ff <= 1'b0;
      end else if (wr_ctrl) begin
         host_act_ff <= hwdata[`FIR_CTRL_HOST_ACT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         thr_hi_ff <= `FIR_THR_HI_RST;
         thr_lo_ff <= `FIR_THR_LO_RST;
         settle_ff <= 32'(SETTLE_CYC);
      end else if (wr_pend_ff) begin
         if (wr_addr_ff == `FIR_OFS_THR_HI) thr_hi_ff <= hwdata;
         if (wr_addr_ff == `FIR_OFS_THR_LO) thr_lo_ff <= hwdata;
         if (wr_addr_ff == `FIR_OFS_SETTLE) settle_ff <= hwdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel staging, interlock check and break mask

   genvar c;
   generate
      for (c = 0; c < `FIR_NCH; c++) begin : g_ch
         localparam logic [11:0] WOFS = `FIR_OFS_STAGE0 + 12'(4 * (c / `FIR_CH_PER_WORD));
         localparam int          LANE = (c % `FIR_CH_PER_WORD) * 8;
         logic [`FIR_RPC-1:0] s;
         logic                on_a;
         logic                on_b;
         logic [2:0]          rails;
         logic [`FIR_RPC-1:0] r;

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               stage_ff[c*`FIR_RPC +: `FIR_RPC] <= '0;
            end else if (wr_pend_ff && wr_addr_ff == WOFS) begin
               stage_ff[c*`FIR_RPC +: `FIR_RPC] <= hwdata[LANE +: `FIR_RPC];
            end
         end

         assign s     = stage_ff[c*`FIR_RPC +: `FIR_RPC];
         assign on_a  = s[`FIR_REL_P_RAIL_A] | s[`FIR_REL_N_RAIL_A];
         assign on_b  = s[`FIR_REL_P_RAIL_B] | s[`FIR_REL_N_RAIL_B];
         assign rails = 3'(s[`FIR_REL_P_RAIL_A]) + 3'(s[`FIR_REL_P_RAIL_B])
                      + 3'(s[`FIR_REL_N_RAIL_A]) + 3'(s[`FIR_REL_N_RAIL_B]);
         assign ch_ok[c] = !(on_a && on_b)
                         && !(s[`FIR_REL_SHORT] && rails > 3'h1);
         // Unchanged channels keep their relays; changed ones open fully
         assign keep_mask[c*`FIR_RPC +: `FIR_RPC] =
            (s == relay_ff[c*`FIR_RPC +: `FIR_RPC]) ? {`FIR_RPC{1'b1}} : '0;
         // Same interlocks, seen on the relays actually driven
         assign r = relay_ff[c*`FIR_RPC +: `FIR_RPC];
         assign rail_clash[c] = (r[`FIR_REL_P_RAIL_A] | r[`FIR_REL_N_RAIL_A])
                              & (r[`FIR_REL_P_RAIL_B] | r[`FIR_REL_N_RAIL_B]);
         assign short_clash[c] = r[`FIR_REL_SHORT] && (3'(r[`FIR_REL_P_RAIL_A]) + 3'(r[`FIR_REL_P_RAIL_B])
                               + 3'(r[`FIR_REL_N_RAIL_A]) + 3'(r[`FIR_REL_N_RAIL_B]) > 3'h1);
      end
   endgenerate

   assign cfg_ok   = &ch_ok;
   assign apply_ok = apply_req && state_ff == fir_pkg::FIR_IDLE && chassis_ready_n_rst && cfg_ok;
   assign reject   = apply_req && state_ff == fir_pkg::FIR_IDLE && chassis_ready_n_rst && !cfg_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Break-before-make sequencer

   assign settle_done = (state_ff == fir_pkg::FIR_SETTLE) && (cnt_ff == 32'h00000000);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= fir_pkg::FIR_IDLE;
         cnt_ff   <= 32'h00000000;
         pend_ff  <= '0;
         relay_ff <= '0;
      end else begin
         case (state_ff)
            fir_pkg::FIR_IDLE: begin
               if (apply_ok) begin
                  pend_ff  <= stage_ff;
                  relay_ff <= relay_ff & keep_mask;
                  cnt_ff   <= settle_ff;
                  state_ff <= fir_pkg::FIR_SETTLE;
               end
            end
            fir_pkg::FIR_SETTLE: begin
               if (cnt_ff == 32'h00000000) begin
                  relay_ff <= pend_ff;
                  state_ff <= fir_pkg::FIR_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 32'h00000001;
               end
            end
            default: state_ff <= fir_pkg::FIR_IDLE;
         endcase
      end
   end

   assign nondefault = |relay_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Fault state, interrupt status and mask

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fault_ff <= 1'b0;
      end else if (reject) begin
         fault_ff <= 1'b1;
      end else if (wr_ctrl && hwdata[`FIR_CTRL_FAULT_CLR]) begin
         fault_ff <= 1'b0;
      end
   end

   always_comb begin
      nxt_sts = sts_ff;
      if (wr_pend_ff && wr_addr_ff == `FIR_OFS_IRQ_STS) begin
         nxt_sts = nxt_sts & ~hwdata[`FIR_STS_BITS-1:0];
      end
      // Set wins over a same-cycle clear
      nxt_sts[`FIR_STS_DONE]   = nxt_sts[`FIR_STS_DONE] | settle_done;
      nxt_sts[`FIR_STS_REJECT] = nxt_sts[`FIR_STS_REJECT] | reject;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sts_ff <= '0;
         msk_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         sts_ff <= nxt_sts;
         irq_ff <= |(nxt_sts & msk_ff);
         if (wr_pend_ff && wr_addr_ff == `FIR_OFS_IRQ_MSK) begin
            msk_ff <= hwdata[`FIR_STS_BITS-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Front panel LEDs

   fir_blink #(
      .HALF_CYC (BLINK_CYC)
   ) u_blink (
      .hclk    (hclk),
      .hresetn (hresetn),
      .blink   (blink)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         led_pg_ff <= 1'b0;
         led_pr_ff <= 1'b0;
      end else begin
         led_pg_ff <= power_good && !fault_ff;
         led_pr_ff <= power_good && fault_ff && blink;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         led_rg_ff <= 1'b0;
         led_ra_ff <= 1'b0;
      end else if (!power_good || !chassis_ready_n_rst) begin
         led_rg_ff <= 1'b0;
         led_ra_ff <= 1'b0;
      end else if (nondefault || host_act_ff) begin
         led_rg_ff <= 1'b0;
         led_ra_ff <= blink;
      end else begin
         led_rg_ff <= 1'b1;
         led_ra_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign hrdata        = hrdata_ff;
   assign hreadyout     = 1'b1;
   assign hresp         = 1'b0;
   assign relay_drive   = relay_ff;
   assign thr_high      = thr_hi_ff;
   assign thr_low       = thr_lo_ff;
   assign irq           = irq_ff;
   assign led_pwr_green = led_pg_ff;
   assign led_pwr_red   = led_pr_ff;
   assign led_rdy_green = led_rg_ff;
   assign led_rdy_amber = led_ra_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   sequence s_apply;
      state_ff == fir_pkg::FIR_IDLE && apply_ok;
   endsequence

   sequence s_close;
      settle_done;
   endsequence

   a_break_first: assert property (@(posedge hclk) disable iff (!hresetn)
      s_apply |=> relay_ff == ($past(relay_ff) & $past(keep_mask)))
      else $error("changed channel not opened first");

   a_settle_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_ff == fir_pkg::FIR_SETTLE && cnt_ff != 32'h00000000) |=> $stable(relay_ff))
      else $error("relays moved during settle");

   a_close_all: assert property (@(posedge hclk) disable iff (!hresetn)
      s_close |=> relay_ff == $past(pend_ff) && state_ff == fir_pkg::FIR_IDLE)
      else $error("configuration not applied at once");

   a_rails_apart: assert property (@(posedge hclk) disable iff (!hresetn)
      rail_clash == '0)
      else $error("rail interlock breached");

   a_reject_keep: assert property (@(posedge hclk) disable iff (!hresetn)
      reject |=> $stable(relay_ff) && sts_ff[`FIR_STS_REJECT] && fault_ff)
      else $error("rejected config changed relays");

   a_short_limit: assert property (@(posedge hclk) disable iff (!hresetn)
      short_clash == '0)
      else $error("short interlock breached");

   a_rdy_off: assert property (@(posedge hclk) disable iff (!hresetn)
      !chassis_ready_n_rst |=> !led_rdy_green && !led_rdy_amber)
      else $error("ready LED lit while held");

   a_rdy_green: assert property (@(posedge hclk) disable iff (!hresetn)
      (hresetn && power_good && chassis_ready_n_rst && !nondefault && !host_act_ff) |=> led_rdy_green)
      else $error("ready LED not green");

   a_pwr_green: assert property (@(posedge hclk) disable iff (!hresetn)
      (hresetn && power_good && !fault_ff) |=> led_pwr_green && !led_pwr_red)
      else $error("power LED wrong");

endmodule

// ### tb/fir_chassis_model.sv
////////////////////////////////////////////////////////////////////////////////
// Chassis side: module power and the active-low ready/reset line
module fir_chassis_model (
   input  wire logic hclk,
   output logic      power_good,
   output logic      chassis_ready_n_rst
);
   timeunit 1ns;
   timeprecision 1ps;

   // Unpowered, line held low until the bench releases it
   initial begin
      power_good          = 1'b0;
      chassis_ready_n_rst = 1'b0;
   end

   task automatic set_lines(input logic pg, input logic rdy);
      @(posedge hclk);
      power_good          <= pg;
      chassis_ready_n_rst <= rdy;
   endtask
endmodule

// ### tb/fault_insertion_relay_control_tb_top.sv
`include "fir_consts.svh"

module fault_insertion_relay_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int SETTLE = 8;

   logic                 hclk;
   logic                 hresetn;
   logic                 hsel;
   logic [31:0]          haddr;
   logic [1:0]           htrans;
   logic                 hwrite;
   logic [2:0]           hsize;
   logic [31:0]          hwdata;
   logic [31:0]          hrdata;
   logic                 hreadyout;
   logic                 hresp;
   logic                 power_good;
   logic                 chassis_ready_n_rst;
   logic [`FIR_NREL-1:0] relay_drive;
   logic [31:0]          thr_high;
   logic [31:0]          thr_low;
   logic                 irq;
   logic                 led_pwr_green;
   logic                 led_pwr_red;
   logic                 led_rdy_green;
   logic                 led_rdy_amber;
   int                   miscompares;
   int                   tests_run;
   logic [6:0]           cfg [16];
   logic [`FIR_NREL-1:0] cur;
   logic                 host_act;
   logic [31:0]          rd;
   logic [6:0]           rej [5];
   int                   settle;

   fir_top #(.SETTLE_CYC(SETTLE), .BLINK_CYC(4)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .power_good(power_good), .chassis_ready_n_rst(chassis_ready_n_rst),
      .relay_drive(relay_drive), .thr_high(thr_high), .thr_low(thr_low), .irq(irq),
      .led_pwr_green(led_pwr_green), .led_pwr_red(led_pwr_red), .led_rdy_green(led_rdy_green),
      .led_rdy_amber(led_rdy_amber)
   );

   fir_chassis_model chassis (
      .hclk(hclk), .power_good(power_good), .chassis_ready_n_rst(chassis_ready_n_rst)
   );

   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report(input logic [127:0] got, input logic [127:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      report({96'h0, got}, {96'h0, exp});
   endtask

   task automatic chk_relay(input logic [`FIR_NREL-1:0] got, input logic [`FIR_NREL-1:0] exp);
      report({16'h0, got}, {16'h0, exp});
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      report({127'h0, got}, {127'h0, exp});
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Bus cycles: each ends with one idle cycle so a read never follows a write directly
   task automatic ahb_write(input logic [11:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {20'h00000, a};
      hwrite <= 1'b1;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
   endtask

   task automatic ahb_read(input logic [11:0] a, output logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {20'h00000, a};
      hwrite <= 1'b0;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      d = hrdata;
      @(posedge hclk);
   endtask

   task automatic read_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      ahb_read(a, d);
      chk_word(d, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic apply();
      for (int k = 0; k < 4; k++) begin
         ahb_write(`FIR_OFS_STAGE0 + 12'(4 * k),
                   {1'b0, cfg[4*k+3], 1'b0, cfg[4*k+2], 1'b0, cfg[4*k+1], 1'b0, cfg[4*k]});
      end
      ahb_write(`FIR_OFS_CTRL, {30'h0, host_act, 1'b1});
   endtask

   task automatic led_blink_chk(input logic amber);
      int n_on;
      int n_off;
      int n_green;
      n_on    = 0;
      n_off   = 0;
      n_green = 0;
      for (int i = 0; i < 16; i++) begin
         @(posedge hclk);
         n_on    += int'((amber ? led_rdy_amber : led_pwr_red) === 1'b1);
         n_off   += int'((amber ? led_rdy_amber : led_pwr_red) === 1'b0);
         n_green += int'((amber ? led_rdy_green : led_pwr_green) !== 1'b0);
      end
      chk_bit(1'(n_on > 0 && n_off > 0 && n_on + n_off == 16 && n_green == 0), 1'b1);
   endtask

   task automatic apply_ok();
      logic [`FIR_NREL-1:0] opn;
      logic [`FIR_NREL-1:0] nw;
      for (int c = 0; c < 16; c++) begin
         nw[7*c +: 7]  = cfg[c];
         opn[7*c +: 7] = (cur[7*c +: 7] == cfg[c]) ? cur[7*c +: 7] : 7'h00;
      end
      apply();
      @(posedge hclk);
      chk_relay(relay_drive, opn);
      // Closing edge lies settle + 1 edges after the opening edge
      repeat (settle - 1) @(posedge hclk);
      chk_relay(relay_drive, opn);
      @(posedge hclk);
      chk_relay(relay_drive, nw);
      read_chk(`FIR_OFS_STAT, {29'h0, 1'(nw != '0), 2'h0});
      cur = nw;
      repeat (2) @(posedge hclk);
   endtask

   task automatic apply_rejected();
      apply();
      repeat (3) @(posedge hclk);
      chk_relay(relay_drive, cur);
      ahb_read(`FIR_OFS_IRQ_STS, rd);
      chk_bit(rd[`FIR_STS_REJECT], 1'b1);
      ahb_read(`FIR_OFS_STAT, rd);
      chk_bit(rd[`FIR_STAT_FAULT], 1'b1);
      led_blink_chk(1'b0);
      ahb_write(`FIR_OFS_CTRL, {29'h0, 1'b1, host_act, 1'b0});
      ahb_write(`FIR_OFS_IRQ_STS, 32'h00000003);
      read_chk(`FIR_OFS_STAT, {29'h0, 1'(cur != '0), 2'h0});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (40000) @(posedge hclk);
      miscompares++;
      wrap_up();
   end

   initial begin
      hresetn     = 1'b0;
      hsel        = 1'b0;
      haddr       = 32'h00000000;
      htrans      = 2'h0;
      hwrite      = 1'b0;
      hsize       = 3'h2;
      hwdata      = 32'h00000000;
      miscompares = 0;
      tests_run   = 0;
      host_act    = 1'b0;
      settle      = SETTLE;
      cur         = '0;
      rej         = '{7'h0C, 7'h24, 7'h18, 7'h30, 7'h16};
      foreach (cfg[c]) cfg[c] = 7'h00;
      repeat (5) @(posedge hclk);
      chk_relay(relay_drive, '0);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      chk_word(thr_high, `FIR_THR_HI_RST);
      chk_word(thr_low, `FIR_THR_LO_RST);
      chk_word({28'h0, led_pwr_green, led_pwr_red, led_rdy_green, led_rdy_amber}, 32'h0);
      chassis.set_lines(1'b1, 1'b0);
      repeat (3) @(posedge hclk);
      chk_word({28'h0, led_pwr_green, led_pwr_red, led_rdy_green, led_rdy_amber}, 32'h8);
      chassis.set_lines(1'b1, 1'b1);
      repeat (3) @(posedge hclk);
      chk_word({28'h0, led_pwr_green, led_pwr_red, led_rdy_green, led_rdy_amber}, 32'hA);
      read_chk(`FIR_OFS_SETTLE, 32'(SETTLE));
      ahb_write(`FIR_OFS_THR_HI, 32'h11223344);
      ahb_write(`FIR_OFS_THR_LO, 32'h05060708);
      read_chk(`FIR_OFS_THR_HI, 32'h11223344);
      read_chk(`FIR_OFS_THR_LO, 32'h05060708);
      chk_word(thr_high, 32'h11223344);
      chk_word(thr_low, 32'h05060708);
      read_chk(12'h0FC, 32'h00000000);
      ahb_write(`FIR_OFS_IRQ_MSK, 32'h00000003);
      // Short plus one rail with load open, a plain loaded pair, a single rail fault
      cfg[0]  = 7'h06;
      cfg[15] = 7'h41;
      cfg[9]  = 7'h10;
      apply_ok();
      chk_bit(irq, 1'b1);
      read_chk(`FIR_OFS_ACTIVE0, 32'h00000006);
      led_blink_chk(1'b1);
      ahb_write(`FIR_OFS_IRQ_STS, 32'h00000003);
      repeat (2) @(posedge hclk);
      chk_bit(irq, 1'b0);
      // Channel 0 changes while channel 15 must stay closed through the open phase
      cfg[0] = 7'h08;
      apply_ok();
      foreach (rej[i]) begin
         cfg[3] = rej[i];
         apply_rejected();
         cfg[3] = 7'h00;
      end
      // Reset in mid-run with relays closed
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk_relay(relay_drive, '0);
      chk_word(thr_high, `FIR_THR_HI_RST);
      hresetn <= 1'b1;
      cur = '0;
      read_chk(`FIR_OFS_SETTLE, 32'(SETTLE));
      ahb_write(`FIR_OFS_SETTLE, 32'h00000003);
      settle = 3;
      read_chk(`FIR_OFS_SETTLE, 32'h00000003);
      ahb_write(`FIR_OFS_IRQ_MSK, 32'h00000000);
      foreach (cfg[c]) cfg[c] = 7'h00;
      for (int j = 0; j < 7; j++) begin
         cfg[15] = 7'(1 << j);
         apply_ok();
         chk_bit(irq, 1'b0);
         read_chk(`FIR_OFS_IRQ_STS, 32'h00000001);
         ahb_write(`FIR_OFS_IRQ_STS, 32'h00000001);
      end
      cfg[15] = 7'h00;
      apply_ok();
      repeat (2) @(posedge hclk);
      chk_word({30'h0, led_rdy_green, led_rdy_amber}, 32'h2);
      host_act = 1'b1;
      ahb_write(`FIR_OFS_CTRL, {30'h0, host_act, 1'b0});
      led_blink_chk(1'b1);
      chk_relay(relay_drive, '0);
      wrap_up();
   end
endmodule
